// ---- hdl/iectl_pkg.sv ----
// Package of constants and types for the interrupt enable and edge control block
package iectl_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] IECTL_OFS_WAKE_EDGE = 16'hFF90;
  localparam logic [15:0] IECTL_OFS_PIN_EDGE  = 16'hFFF2;
  localparam logic [15:0] IECTL_OFS_EN_ONE    = 16'hFFF3;
  localparam logic [15:0] IECTL_OFS_EN_TWO    = 16'hFFF4;
  localparam logic [15:0] IECTL_OFS_FLG_ONE   = 16'hFFF6;
  localparam logic [15:0] IECTL_OFS_FLG_TWO   = 16'hFFF7;
  localparam logic [15:0] IECTL_OFS_FLG_WAKE  = 16'hFFF9;
  // ----------------------------------------------------------------
  // Reset values and writable-bit masks (the other bits are fixed at one)
  // ----------------------------------------------------------------
  localparam logic [7:0] IECTL_RST_WAKE_EDGE = 8'h00;
  localparam logic [7:0] IECTL_RST_PIN_EDGE  = 8'hFC;
  localparam logic [7:0] IECTL_RST_EN_ONE    = 8'h58;
  localparam logic [7:0] IECTL_RST_EN_TWO    = 8'h32;
  localparam logic [7:0] IECTL_RST_FLG_ONE   = 8'h78;
  localparam logic [7:0] IECTL_RST_FLG_TWO   = 8'h32;
  localparam logic [7:0] IECTL_RST_FLG_WAKE  = 8'h00;
  localparam logic [7:0] IECTL_RW_PIN_EDGE   = 8'h03;
  localparam logic [7:0] IECTL_RW_EN_ONE     = 8'hA7;
  localparam logic [7:0] IECTL_RW_EN_TWO     = 8'hCD;
  // Flags one has its own reserved layout (flags two matches enable two); bit 5 of flags one is fixed at 1
  localparam logic [7:0] IECTL_RW_FLG_ONE    = 8'h87;
  localparam logic [7:0] IECTL_RW_FLG_TWO    = 8'hCD;
  localparam logic [7:0] IECTL_UNMAPPED_RD   = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int IECTL_B_PIN0     = 0;
  localparam int IECTL_B_PIN1     = 1;
  localparam int IECTL_B_AUX      = 2;
  localparam int IECTL_B_WAKE     = 5;
  localparam int IECTL_B_TMR_A    = 7;
  localparam int IECTL_B_ASYNC    = 0;
  localparam int IECTL_B_TMR_LOW  = 2;
  localparam int IECTL_B_TMR_HIGH = 3;
  localparam int IECTL_B_CONV     = 6;
  localparam int IECTL_B_DXFER    = 7;
  // ----------------------------------------------------------------
  // Sources in priority order, highest first
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    IECTL_SRC_NONE, IECTL_SRC_PIN0, IECTL_SRC_PIN1, IECTL_SRC_AUX, IECTL_SRC_WAKE,
    IECTL_SRC_TMR_A, IECTL_SRC_ASYNC, IECTL_SRC_TMR_LOW, IECTL_SRC_TMR_HIGH,
    IECTL_SRC_CONV, IECTL_SRC_DXFER
  } iectl_src_type;
  localparam int IECTL_NSRC = 10;
  // Peripheral events, one-cycle pulses on the system clock
  typedef struct packed {
    logic tmr_a_ovf;
    logic async_ovf;
    logic tmr_low;
    logic tmr_high;
    logic conv_end;
    logic dxfer;
  } iectl_evt_type;
  // Register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } iectl_bus_type;
endpackage

// ---- hdl/iectl_top.sv ----
// Interrupt enable, edge select and request flag registers with priority request output
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
module iectl_top
  import iectl_pkg::*;
(
  // Clock and reset
  input  wire logic          i_clk_sys,
  input  wire logic          i_rstn,
  // Register bus
  input  wire iectl_bus_type i_bus,
  output logic [7:0]         o_rdata,
  // Event sources
  input  wire logic          i_ext_pin0,
  input  wire logic          i_ext_pin1,
  input  wire logic          i_aux_edge_input,
  input  wire logic [7:0]    i_wake_pin,
  input  wire iectl_evt_type i_evt,
  // CPU side
  input  wire logic          i_cpu_mask,
  output logic               o_irq,
  output iectl_src_type      o_irq_src
);
  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  // Three stages; the edge is seen where stages two and three disagree
  logic [10:0] pin_raw;
  logic [10:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
  logic [10:0] rise, fall;
  assign pin_raw = {i_wake_pin, i_aux_edge_input, i_ext_pin1, i_ext_pin0};
  always_comb begin
    s1_d = pin_raw;
    s2_d = s1_q;
    s3_d = s2_q;
  end
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] wedge_q, pedge_q, en1_q, en2_q, f1_q, f2_q, fw_q;
  logic [7:0] wedge_d, pedge_d, en1_d, en2_d, f1_d, f2_d, fw_d;
  logic [7:0] set1, set2, setw, rdata_d;
  logic       wr_hit;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  // Wake pins: falling edge when select bit is 0, rising when 1
  always_comb begin
    setw = (rise[10:3] & wedge_q) | (fall[10:3] & ~wedge_q);
    set1 = 8'h00;
    set2 = 8'h00;
    set1[IECTL_B_PIN0]     = pedge_q[IECTL_B_PIN0] ? rise[0] : fall[0];
    set1[IECTL_B_PIN1]     = pedge_q[IECTL_B_PIN1] ? rise[1] : fall[1];
    set1[IECTL_B_AUX]      = fall[2];
    set1[IECTL_B_TMR_A]    = i_evt.tmr_a_ovf;
    set2[IECTL_B_ASYNC]    = i_evt.async_ovf;
    set2[IECTL_B_TMR_LOW]  = i_evt.tmr_low;
    set2[IECTL_B_TMR_HIGH] = i_evt.tmr_high;
    set2[IECTL_B_CONV]     = i_evt.conv_end;
    set2[IECTL_B_DXFER]    = i_evt.dxfer;
  end

  always_comb begin
    wr_hit  = i_bus.wr;
    wedge_d = wedge_q;
    pedge_d = pedge_q;
    en1_d   = en1_q;
    en2_d   = en2_q;
    f1_d    = f1_q;
    f2_d    = f2_q;
    fw_d    = fw_q;
    if (wr_hit && hit(i_bus.addr, IECTL_OFS_WAKE_EDGE)) begin
      wedge_d = i_bus.wdata;
    end else if (wr_hit && hit(i_bus.addr, IECTL_OFS_PIN_EDGE)) begin
      pedge_d = (i_bus.wdata & IECTL_RW_PIN_EDGE) | ~IECTL_RW_PIN_EDGE;
    end else if (wr_hit && hit(i_bus.addr, IECTL_OFS_EN_ONE)) begin
      en1_d = (i_bus.wdata & IECTL_RW_EN_ONE) | ~IECTL_RW_EN_ONE;
    end else if (wr_hit && hit(i_bus.addr, IECTL_OFS_EN_TWO)) begin
      en2_d = (i_bus.wdata & IECTL_RW_EN_TWO) | ~IECTL_RW_EN_TWO;
    end else if (wr_hit && hit(i_bus.addr, IECTL_OFS_FLG_ONE)) begin
      f1_d = f1_q & (i_bus.wdata | ~IECTL_RW_FLG_ONE);
    end else if (wr_hit && hit(i_bus.addr, IECTL_OFS_FLG_TWO)) begin
      f2_d = f2_q & (i_bus.wdata | ~IECTL_RW_FLG_TWO);
    end else if (wr_hit && hit(i_bus.addr, IECTL_OFS_FLG_WAKE)) begin
      fw_d = fw_q & i_bus.wdata;
    end
    // Set wins over a clear in the same cycle; flags set even while masked
    f1_d = f1_d | (set1 & IECTL_RW_FLG_ONE);
    f2_d = f2_d | (set2 & IECTL_RW_FLG_TWO);
    fw_d = fw_d | setw;
  end

  // Read data stands only in the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (!i_bus.rd) begin
      rdata_d = 8'h00;
    end else if (hit(i_bus.addr, IECTL_OFS_WAKE_EDGE)) begin
      rdata_d = wedge_q;
    end else if (hit(i_bus.addr, IECTL_OFS_PIN_EDGE)) begin
      rdata_d = pedge_q;
    end else if (hit(i_bus.addr, IECTL_OFS_EN_ONE)) begin
      rdata_d = en1_q;
    end else if (hit(i_bus.addr, IECTL_OFS_EN_TWO)) begin
      rdata_d = en2_q;
    end else if (hit(i_bus.addr, IECTL_OFS_FLG_ONE)) begin
      rdata_d = f1_q;
    end else if (hit(i_bus.addr, IECTL_OFS_FLG_TWO)) begin
      rdata_d = f2_q;
    end else if (hit(i_bus.addr, IECTL_OFS_FLG_WAKE)) begin
      rdata_d = fw_q;
    end else begin
      rdata_d = IECTL_UNMAPPED_RD;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      wedge_q <= IECTL_RST_WAKE_EDGE;
      pedge_q <= IECTL_RST_PIN_EDGE;
      en1_q   <= IECTL_RST_EN_ONE;
      en2_q   <= IECTL_RST_EN_TWO;
      f1_q    <= IECTL_RST_FLG_ONE;
      f2_q    <= IECTL_RST_FLG_TWO;
      fw_q    <= IECTL_RST_FLG_WAKE;
      o_rdata <= 8'h00;
    end else begin
      wedge_q <= wedge_d;
      pedge_q <= pedge_d;
      en1_q   <= en1_d;
      en2_q   <= en2_d;
      f1_q    <= f1_d;
      f2_q    <= f2_d;
      fw_q    <= fw_d;
      o_rdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Request gating and priority
  // ----------------------------------------------------------------
  // Index 0 is highest priority
  logic [IECTL_NSRC-1:0] pend;
  logic                  irq_d;
  iectl_src_type         src_d;
  always_comb begin
    pend[0] = f1_q[IECTL_B_PIN0] & en1_q[IECTL_B_PIN0];
    pend[1] = f1_q[IECTL_B_PIN1] & en1_q[IECTL_B_PIN1];
    pend[2] = f1_q[IECTL_B_AUX] & en1_q[IECTL_B_AUX];
    pend[3] = (|fw_q) & en1_q[IECTL_B_WAKE];
    pend[4] = f1_q[IECTL_B_TMR_A] & en1_q[IECTL_B_TMR_A];
    pend[5] = f2_q[IECTL_B_ASYNC] & en2_q[IECTL_B_ASYNC];
    pend[6] = f2_q[IECTL_B_TMR_LOW] & en2_q[IECTL_B_TMR_LOW];
    pend[7] = f2_q[IECTL_B_TMR_HIGH] & en2_q[IECTL_B_TMR_HIGH];
    pend[8] = f2_q[IECTL_B_CONV] & en2_q[IECTL_B_CONV];
    pend[9] = f2_q[IECTL_B_DXFER] & en2_q[IECTL_B_DXFER];
  end
  always_comb begin
    src_d = IECTL_SRC_NONE;
    for (int i = IECTL_NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        src_d = iectl_src_type'(4'(i + 1));
      end
    end
    irq_d = (|pend) & ~i_cpu_mask;
    if (i_cpu_mask) begin
      src_d = IECTL_SRC_NONE;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq     <= 1'b0;
      o_irq_src <= IECTL_SRC_NONE;
    end else begin
      o_irq     <= irq_d;
      o_irq_src <= src_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_wr_one_flags;
    i_bus.wr && i_bus.addr == IECTL_OFS_FLG_ONE;
  endsequence
  a_masked_no_irq: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_cpu_mask |=> !o_irq) else $error("irq raised while masked");
  a_irq_needs_pend: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_irq |-> $past(|pend)) else $error("irq without pending source");
  a_edge_fixed_ones: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    pedge_q[7:2] == 6'h3F) else $error("edge select fixed bits lost");
  a_en1_fixed_ones: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (en1_q & ~IECTL_RW_EN_ONE) == ~IECTL_RW_EN_ONE) else $error("enable one fixed bits lost");
  a_en2_fixed_ones: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (en2_q & ~IECTL_RW_EN_TWO) == ~IECTL_RW_EN_TWO) else $error("enable two fixed bits lost");
  a_write_no_set: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    s_wr_one_flags ##0 !f1_q[IECTL_B_TMR_A] ##0 !i_evt.tmr_a_ovf |=> !f1_q[IECTL_B_TMR_A])
    else $error("flag set by write");
  a_flag_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    f2_q[IECTL_B_CONV] && !(i_bus.wr && i_bus.addr == IECTL_OFS_FLG_TWO) |=> f2_q[IECTL_B_CONV])
    else $error("flag dropped without clear");
  a_pin0_rise: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    pedge_q[IECTL_B_PIN0] && rise[0] |=> f1_q[IECTL_B_PIN0]) else $error("pin0 rise missed");
  a_pin1_fall: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !pedge_q[IECTL_B_PIN1] && fall[1] |=> f1_q[IECTL_B_PIN1]) else $error("pin1 fall missed");
  a_prio_top: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    pend[0] && !i_cpu_mask |=> o_irq_src == IECTL_SRC_PIN0) else $error("priority wrong");
  a_wake_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !en1_q[IECTL_B_WAKE] |-> !pend[3]) else $error("wake not gated");
  a_tmr_gates: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !en2_q[IECTL_B_TMR_HIGH] && !en2_q[IECTL_B_TMR_LOW] |-> !pend[6] && !pend[7])
    else $error("timer not gated");
  a_one_edge_once: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    rise[0] |=> !rise[0]) else $error("edge seen twice");

  // ----------------------------------------------------------------
  // Further checks on flags and gating
  // ----------------------------------------------------------------
  // A clearing write only counts when no event hits the same bit
  sequence s_wr_two_clear_conv;
    i_bus.wr && i_bus.addr == IECTL_OFS_FLG_TWO && !i_bus.wdata[IECTL_B_CONV];
  endsequence
  sequence s_no_conv_event;
    !i_evt.conv_end;
  endsequence
  a_flg1_fixed_ones: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (f1_q & ~IECTL_RW_FLG_ONE) == ~IECTL_RW_FLG_ONE) else $error("flags one fixed bits lost");
  a_flg2_fixed_ones: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (f2_q & ~IECTL_RW_FLG_TWO) == ~IECTL_RW_FLG_TWO) else $error("flags two fixed bits lost");
  a_flag_clear_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    s_wr_two_clear_conv ##0 s_no_conv_event |=> !f2_q[IECTL_B_CONV]) else $error("flag clear missed");
  a_set_wins_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_evt.conv_end |=> f2_q[IECTL_B_CONV]) else $error("event flag lost");
  a_pin0_fall: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !pedge_q[IECTL_B_PIN0] && fall[0] |=> f1_q[IECTL_B_PIN0]) else $error("pin0 fall missed");
  a_pin1_rise: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    pedge_q[IECTL_B_PIN1] && rise[1] |=> f1_q[IECTL_B_PIN1]) else $error("pin1 rise missed");
  a_wake0_fall: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !wedge_q[0] && fall[3] |=> fw_q[0]) else $error("wake fall missed");
  a_tmr_a_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !en1_q[IECTL_B_TMR_A] |-> !pend[4]) else $error("timer a not gated");
  a_aux_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !en1_q[IECTL_B_AUX] |-> !pend[2]) else $error("aux not gated");
  a_pin_gates: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !en1_q[IECTL_B_PIN0] && !en1_q[IECTL_B_PIN1] |-> !pend[0] && !pend[1]) else $error("pins not gated");
  a_dxfer_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !en2_q[IECTL_B_DXFER] |-> !pend[9]) else $error("transfer not gated");
  a_conv_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !en2_q[IECTL_B_CONV] |-> !pend[8]) else $error("converter not gated");
  a_async_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !en2_q[IECTL_B_ASYNC] |-> !pend[5]) else $error("counter not gated");
  a_irq_follows: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (|pend) && !i_cpu_mask |=> o_irq) else $error("pending request not raised");
endmodule

// ---- tb/iectl_cpu_model.sv ----
// CPU core model: owns the global mask and takes the presented request
`timescale 1ns/1ns
module iectl_cpu_model
  import iectl_pkg::*;
(
  // Clock and reset
  input  wire logic          i_clk_sys,
  input  wire logic          i_rstn,
  // Block side
  input  wire logic          i_irq,
  input  wire iectl_src_type i_irq_src,
  // Bench side
  input  wire logic          i_mask_req,
  output logic               o_cpu_mask,
  output iectl_src_type      o_taken_src
);
  // Core leaves reset masked; from then on the mask follows the bench mask request one cycle later
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cpu_mask  <= 1'b1;
      o_taken_src <= IECTL_SRC_NONE;
    end else begin
      o_cpu_mask <= i_mask_req;
      if (i_irq && !o_cpu_mask) begin
        o_taken_src <= i_irq_src;
      end
    end
  end
endmodule

// ---- tb/testbench.sv ----
// Self-checking testbench for the interrupt enable and edge control block
`timescale 1ns/1ns
module testbench;
  import iectl_pkg::*;
  logic          clk_sys = 1'b0;
  logic          rstn = 1'b0;
  iectl_bus_type bus = '0;
  logic [7:0]    rdata;
  logic          pin0 = 1'b1;
  logic          pin1 = 1'b1;
  logic          aux = 1'b1;
  logic [7:0]    wake = 8'hFF;
  iectl_evt_type evt = '0;
  logic          cpu_mask;
  logic          mask_req = 1'b0;
  logic          irq;
  iectl_src_type irq_src;
  iectl_src_type taken_src;
  int            fail_count = 0;
  int            n_checks = 0;
  int            cycles = 0;

  always #5 clk_sys = ~clk_sys;

  iectl_top dut (.i_clk_sys(clk_sys), .i_rstn(rstn), .i_bus(bus), .o_rdata(rdata), .i_ext_pin0(pin0),
    .i_ext_pin1(pin1), .i_aux_edge_input(aux), .i_wake_pin(wake), .i_evt(evt), .i_cpu_mask(cpu_mask),
    .o_irq(irq), .o_irq_src(irq_src));
  iectl_cpu_model cpu (.i_clk_sys(clk_sys), .i_rstn(rstn), .i_irq(irq), .i_irq_src(irq_src),
    .i_mask_req(mask_req), .o_cpu_mask(cpu_mask), .o_taken_src(taken_src));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys) bus <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk_sys) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys) bus <= '0;
    #1 chk(nm, exp, rdata);
  endtask

  task automatic req(input logic e, input iectl_src_type s, input string nm);
    cyc(3);
    #1 chk(nm, {3'h0, e, s}, {3'h0, irq, irq_src});
  endtask

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(IECTL_OFS_PIN_EDGE, 8'hFC, "edge rst");
    rd(IECTL_OFS_EN_ONE, 8'h58, "en1 rst");
    rd(IECTL_OFS_EN_TWO, 8'h32, "en2 rst");
    rd(IECTL_OFS_FLG_ONE, 8'h78, "flg1 rst");
    rd(IECTL_OFS_FLG_TWO, 8'h32, "flg2 rst");
    rd(IECTL_OFS_FLG_WAKE, 8'h00, "wflg rst");
    rd(IECTL_OFS_WAKE_EDGE, 8'h00, "wedge rst");
    rd(16'hFFF5, 8'h00, "unmapped");
    wr(IECTL_OFS_PIN_EDGE, 8'h00);
    wr(IECTL_OFS_EN_ONE, 8'h00);
    wr(IECTL_OFS_EN_TWO, 8'h00);
    rd(IECTL_OFS_PIN_EDGE, 8'hFC, "edge w0");
    rd(IECTL_OFS_EN_ONE, 8'h58, "en1 w0");
    rd(IECTL_OFS_EN_TWO, 8'h32, "en2 w0");
    wr(IECTL_OFS_EN_TWO, 8'hFF);
    rd(IECTL_OFS_EN_TWO, 8'hFF, "en2 w1");
    wr(IECTL_OFS_EN_TWO, 8'h00);
    $display("Test registers done");
  endtask

  // One pass per peripheral event, each on its own enable bit
  task automatic t_events();
    int            bits[6] = '{7, 0, 2, 3, 6, 7};
    iectl_src_type srcs[6] = '{IECTL_SRC_TMR_A, IECTL_SRC_ASYNC, IECTL_SRC_TMR_LOW, IECTL_SRC_TMR_HIGH,
                               IECTL_SRC_CONV, IECTL_SRC_DXFER};
    logic [15:0]   ea;
    logic [15:0]   fa;
    logic [7:0]    fx;
    logic [7:0]    bv;
    for (int i = 0; i < 6; i++) begin
      ea = (i == 0) ? IECTL_OFS_EN_ONE : IECTL_OFS_EN_TWO;
      fa = (i == 0) ? IECTL_OFS_FLG_ONE : IECTL_OFS_FLG_TWO;
      fx = (i == 0) ? 8'h78 : 8'h32;
      bv = 8'h01 << bits[i];
      @(posedge clk_sys) evt <= iectl_evt_type'(6'h20 >> i);
      @(posedge clk_sys) evt <= '0;
      req(1'b0, IECTL_SRC_NONE, "disabled");
      wr(fa, 8'hFF);
      rd(fa, fx | bv, "flag set");
      wr(ea, bv);
      req(1'b1, srcs[i], "enabled");
      rd(fa, fx | bv, "flag kept");
      wr(fa, 8'h00);
      req(1'b0, IECTL_SRC_NONE, "cleared");
      wr(ea, 8'h00);
    end
    $display("Test events done");
  endtask

  task automatic t_pins();
    wr(IECTL_OFS_PIN_EDGE, 8'h01);
    wr(IECTL_OFS_EN_ONE, 8'h07);
    @(posedge clk_sys) pin0 <= 1'b0;
    cyc(6);
    rd(IECTL_OFS_FLG_ONE, 8'h78, "pin0 fall");
    @(posedge clk_sys) pin0 <= 1'b1;
    cyc(6);
    rd(IECTL_OFS_FLG_ONE, 8'h79, "pin0 rise");
    @(posedge clk_sys) pin1 <= 1'b0;
    req(1'b1, IECTL_SRC_PIN0, "pin0 req");
    cyc(3);
    rd(IECTL_OFS_FLG_ONE, 8'h7B, "pin1 fall");
    req(1'b1, IECTL_SRC_PIN0, "pin prio");
    wr(IECTL_OFS_FLG_ONE, 8'hFE);
    req(1'b1, IECTL_SRC_PIN1, "pin1 req");
    wr(IECTL_OFS_FLG_ONE, 8'h00);
    @(posedge clk_sys) aux <= 1'b0;
    cyc(6);
    rd(IECTL_OFS_FLG_ONE, 8'h7C, "aux flag");
    req(1'b1, IECTL_SRC_AUX, "aux req");
    wr(IECTL_OFS_FLG_ONE, 8'h00);
    wr(IECTL_OFS_EN_ONE, 8'h00);
    $display("Test pins done");
  endtask

  task automatic t_wake_mask();
    @(posedge clk_sys) wake <= 8'hF7;
    cyc(6);
    rd(IECTL_OFS_FLG_WAKE, 8'h08, "wake flag");
    req(1'b0, IECTL_SRC_NONE, "wake off");
    wr(IECTL_OFS_EN_ONE, 8'hA0);
    req(1'b1, IECTL_SRC_WAKE, "wake req");
    @(posedge clk_sys) mask_req <= 1'b1;
    @(posedge clk_sys) evt <= '{tmr_a_ovf: 1'b1, default: 1'b0};
    @(posedge clk_sys) evt <= '0;
    req(1'b0, IECTL_SRC_NONE, "masked");
    rd(IECTL_OFS_FLG_ONE, 8'hF8, "masked flag");
    wr(IECTL_OFS_FLG_WAKE, 8'h00);
    @(posedge clk_sys) mask_req <= 1'b0;
    req(1'b1, IECTL_SRC_TMR_A, "unmasked");
    #1 chk("taken", {4'h0, IECTL_SRC_TMR_A}, {4'h0, taken_src});
    wr(IECTL_OFS_FLG_ONE, 8'h00);
    req(1'b0, IECTL_SRC_NONE, "idle");
    $display("Test wake and mask done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------
  initial begin
    cyc(10);
    @(posedge clk_sys) rstn <= 1'b1;
    cyc(4);
    t_regs();
    t_events();
    t_pins();
    t_wake_mask();
    end_of_test();
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      end_of_test();
    end
  end
endmodule
